// ===== core/msit_regs.svh
// Register offsets, fields, reset values and timing counts
`ifndef MSIT_REGS_SVH
`define MSIT_REGS_SVH

`define MSIT_CTRL_OFF 12'h000
`define MSIT_STAT_OFF 12'h004
`define MSIT_SPH_OFF 12'h008
`define MSIT_TBS_OFF 12'h00c
`define MSIT_TRIP_OFF 12'h010
`define MSIT_EVENT_OFF 12'h014
`define MSIT_TMR0_OFF 12'h018

`define MSIT_LIMIT_LSB 0
`define MSIT_LIMIT_MSB 2
`define MSIT_TBSMIN_LSB 8
`define MSIT_TBSMIN_MSB 15
`define MSIT_RLYSEL_LSB 16
`define MSIT_RLYSEL_MSB 17

`define MSIT_LIMIT_RST 3'h3
`define MSIT_LIMIT_MAX 3'h5
`define MSIT_TBSMIN_RST 8'h00
`define MSIT_RLYSEL_RST 2'h1
`define MSIT_EVT_INHIBIT 5'h10

`define MSIT_NTIMERS 5
`define MSIT_CLK_HZ 200000000
`define MSIT_TICK_SEC 1
`define MSIT_START_MIN 60
`define MSIT_SEC_PER_MIN 60
`define MSIT_START_SECS (`MSIT_START_MIN * `MSIT_SEC_PER_MIN)
`define MSIT_STOP_PCT 5
`define MSIT_STOP_PERMILLE (`MSIT_STOP_PCT * 10)

`endif

// ===== core/msit_pkg.sv
// Types shared by the start supervision block
package msit_pkg;
	typedef logic [11:0] msit_timer_t;
	typedef logic [13:0] msit_tbs_t;
	// Trip source code, sixteen sources
	typedef logic [3:0] msit_cause_t;
	// Bit 4 set means inhibit lockout
	typedef logic [4:0] msit_event_t;
	typedef enum logic [1:0] {
		MSIT_STOPPED = 2'b01,
		MSIT_RUNNING = 2'b10
	} msit_motor_e;
endpackage

// ===== core/msit_pin_sync.sv
// Two-flop synchroniser with press detect for an active-low contact
`timescale 1ns/1ps
`default_nettype none
module msit_pin_sync (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pin_n,
	output logic level_n,
	output logic press
);
	logic [2:0] sync_q;
	logic [2:0] sync_d;

	always_comb begin
		sync_d = {sync_q[1:0], pin_n};
	end

	// Released contact reads high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_q <= 3'h7;
		end else begin
			sync_q <= sync_d;
		end
	end

	assign level_n = sync_q[1];
	assign press = ~sync_q[1] & sync_q[2];

	press_single_a: assert property (@(posedge pclk) disable iff (!presetn)
		press |=> !press)
		else $error("press lasted more than one cycle");
endmodule // msit_pin_sync
`default_nettype wire

// ===== core/msit_top.sv
// Motor start supervision: start timers, lockouts, trip and event causes
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "msit_regs.svh"
module msit_top #(
	parameter int TICK_CYCLES = `MSIT_CLK_HZ * `MSIT_TICK_SEC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [9:0] motor_current_pm,
	input wire logic emerg_restart_n,
	input wire logic trip_pulse,
	input wire msit_pkg::msit_cause_t trip_cause,
	input wire logic ext_inhibit,
	output logic motor_running,
	output logic start_inhibit,
	output logic inhibit_trip_relay,
	output logic first_auxiliary_output
);
	import msit_pkg::*;

	localparam int NT = `MSIT_NTIMERS;
	localparam logic [9:0] STOP_PM = 10'(`MSIT_STOP_PERMILLE);
	localparam msit_timer_t START_SECS = 12'(`MSIT_START_SECS);

	logic emerg_press;
	logic tick;
	logic [27:0] tick_q;
	logic [27:0] tick_d;
	msit_motor_e motor_q;
	msit_motor_e motor_d;
	logic start_evt;
	msit_timer_t tmr_q [NT];
	msit_timer_t tmr_d [NT];
	logic [NT-1:0] busy;
	msit_timer_t min_val;
	logic [2:0] min_idx;
	logic [2:0] free_idx;
	logic free_ok;
	logic [2:0] load_idx;
	logic [2:0] active_cnt;
	logic [14:0] tmr_sum;
	logic [2:0] limit_q;
	logic [2:0] limit_d;
	logic [7:0] tbs_min_q;
	logic [7:0] tbs_min_d;
	logic [1:0] rlysel_q;
	logic [1:0] rlysel_d;
	logic sph_q;
	logic sph_d;
	msit_timer_t sph_lock;
	msit_tbs_t tbs_q;
	msit_tbs_t tbs_d;
	logic tbs_lock;
	logic inh_any;
	logic inh_prev_q;
	logic inh_rise;
	msit_cause_t trip_q;
	msit_cause_t trip_d;
	msit_event_t event_q;
	msit_event_t event_d;
	logic trly_q;
	logic trly_d;
	logic aux_q;
	logic aux_d;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic pslverr_q;
	logic pslverr_d;
	logic apb_setup;
	logic apb_wr;
	logic [2:0] wr_limit;

	msit_pin_sync u_emerg (
		.pclk(pclk),
		.presetn(presetn),
		.pin_n(emerg_restart_n),
		.level_n(),
		.press(emerg_press)
	);

	// One-second time base
	assign tick = (tick_q == 28'(TICK_CYCLES - 1));
	always_comb begin
		tick_d = tick ? 28'h0 : tick_q + 28'h1;
	end

	// Motor state from current level
	always_comb begin
		motor_d = motor_q;
		start_evt = 1'b0;
		case (motor_q)
			MSIT_STOPPED: begin
				if (motor_current_pm >= STOP_PM) begin
					motor_d = MSIT_RUNNING;
					start_evt = 1'b1;
				end
			end
			MSIT_RUNNING: begin
				if (motor_current_pm < STOP_PM) begin
					motor_d = MSIT_STOPPED;
				end
			end
			default: begin
				motor_d = MSIT_STOPPED;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_q <= 28'h0;
			motor_q <= MSIT_STOPPED;
		end else begin
			tick_q <= tick_d;
			motor_q <= motor_d;
		end
	end

	assign motor_running = (motor_q == MSIT_RUNNING);

	// Smallest running timer, free slot, count and sum
	always_comb begin
		min_val = 12'h000;
		min_idx = 3'h0;
		free_ok = 1'b0;
		free_idx = 3'h0;
		active_cnt = 3'h0;
		tmr_sum = 15'h0000;
		for (int i = NT - 1; i >= 0; i--) begin
			tmr_sum = tmr_sum + 15'(tmr_q[i]);
			if (busy[i]) begin
				active_cnt = active_cnt + 3'h1;
				if (min_val == 12'h000 || tmr_q[i] <= min_val) begin
					min_val = tmr_q[i];
					min_idx = 3'(i);
				end
			end else begin
				free_ok = 1'b1;
				free_idx = 3'(i);
			end
		end
	end

	// With every slot busy (limit OFF) the oldest start is recycled
	assign load_idx = free_ok ? free_idx : min_idx;

	for (genvar i = 0; i < NT; i++) begin : g_tmr
		assign busy[i] = (tmr_q[i] != 12'h000);
		always_comb begin
			tmr_d[i] = tmr_q[i];
			if (tick && busy[i]) begin
				tmr_d[i] = tmr_q[i] - 12'h001;
			end
			if (emerg_press && busy[i] && min_idx == 3'(i)) begin
				tmr_d[i] = 12'h000;
			end
			if (start_evt && load_idx == 3'(i)) begin
				tmr_d[i] = START_SECS;
			end
		end
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				tmr_q[i] <= 12'h000;
			end else begin
				tmr_q[i] <= tmr_d[i];
			end
		end
	end

	// Starts-per-hour inhibit; a press drops it before the count settles
	always_comb begin
		sph_d = (limit_q != 3'h0) && (active_cnt >= limit_q);
		if (emerg_press) begin
			sph_d = 1'b0;
		end
	end
	assign sph_lock = sph_q ? min_val : 12'h000;

	// Time-between-starts lockout
	always_comb begin
		tbs_d = tbs_q;
		if (tbs_min_q == 8'h00) begin
			tbs_d = 14'h0000;
		end else if (start_evt) begin
			tbs_d = 14'(tbs_min_q * `MSIT_SEC_PER_MIN);
		end else if (tick && tbs_q != 14'h0000) begin
			tbs_d = tbs_q - 14'h0001;
		end
	end
	assign tbs_lock = (motor_q == MSIT_STOPPED) && (tbs_q != 14'h0000);

	assign inh_any = sph_q | tbs_lock | ext_inhibit;
	assign inh_rise = inh_any & ~inh_prev_q;
	assign start_inhibit = inh_any;

	// Trip and event records; an inhibit in the same cycle wins the event
	always_comb begin
		trip_d = trip_q;
		event_d = event_q;
		if (trip_pulse) begin
			trip_d = trip_cause;
			event_d = {1'b0, trip_cause};
		end
		if (inh_rise) begin
			event_d = `MSIT_EVT_INHIBIT;
		end
		trly_d = inh_any & rlysel_q[0];
		aux_d = inh_any & rlysel_q[1];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sph_q <= 1'b0;
			tbs_q <= 14'h0000;
			inh_prev_q <= 1'b0;
			trip_q <= 4'h0;
			event_q <= 5'h00;
			trly_q <= 1'b0;
			aux_q <= 1'b0;
		end else begin
			sph_q <= sph_d;
			tbs_q <= tbs_d;
			inh_prev_q <= inh_any;
			trip_q <= trip_d;
			event_q <= event_d;
			trly_q <= trly_d;
			aux_q <= aux_d;
		end
	end

	assign inhibit_trip_relay = trly_q;
	assign first_auxiliary_output = aux_q;

	// APB slave: zero wait states, read data captured in setup
	assign pready = 1'b1;
	assign apb_setup = psel & ~penable;
	assign apb_wr = psel & penable & pwrite;
	assign wr_limit = pwdata[`MSIT_LIMIT_MSB:`MSIT_LIMIT_LSB];

	always_comb begin
		limit_d = limit_q;
		tbs_min_d = tbs_min_q;
		rlysel_d = rlysel_q;
		if (apb_wr && paddr == `MSIT_CTRL_OFF) begin
			// Limits above five saturate
			limit_d = (wr_limit > `MSIT_LIMIT_MAX) ? `MSIT_LIMIT_MAX
				: wr_limit;
			tbs_min_d = pwdata[`MSIT_TBSMIN_MSB:`MSIT_TBSMIN_LSB];
			rlysel_d = pwdata[`MSIT_RLYSEL_MSB:`MSIT_RLYSEL_LSB];
		end
	end

	always_comb begin
		prdata_d = prdata_q;
		pslverr_d = pslverr_q;
		if (apb_setup) begin
			prdata_d = 32'h0000_0000;
			pslverr_d = 1'b0;
			case (paddr)
				`MSIT_CTRL_OFF: begin
					prdata_d = {14'h0000, rlysel_q, tbs_min_q, 5'h00, limit_q};
				end
				`MSIT_STAT_OFF: begin
					prdata_d = {26'h0000000, active_cnt, motor_running,
						tbs_lock, sph_q};
				end
				`MSIT_SPH_OFF: begin
					prdata_d = {20'h00000, sph_lock};
				end
				`MSIT_TBS_OFF: begin
					prdata_d = {18'h00000, tbs_q};
				end
				`MSIT_TRIP_OFF: begin
					prdata_d = {28'h0000000, trip_q};
				end
				`MSIT_EVENT_OFF: begin
					prdata_d = {27'h0000000, event_q};
				end
				default: begin
					pslverr_d = 1'b1;
					for (int i = 0; i < NT; i++) begin
						if (paddr == 12'(`MSIT_TMR0_OFF + 4 * i)) begin
							prdata_d = {20'h00000, tmr_q[i]};
							pslverr_d = 1'b0;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			limit_q <= `MSIT_LIMIT_RST;
			tbs_min_q <= `MSIT_TBSMIN_RST;
			rlysel_q <= `MSIT_RLYSEL_RST;
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else begin
			limit_q <= limit_d;
			tbs_min_q <= tbs_min_d;
			rlysel_q <= rlysel_d;
			prdata_q <= prdata_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign prdata = prdata_q;
	assign pslverr = pslverr_q;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence quiet_press_s;
		emerg_press && !start_evt && !tick && busy != '0;
	endsequence

	sequence clean_start_s;
		start_evt && free_ok && !emerg_press && !tick;
	endsequence

	start_load_a: assert property (
		clean_start_s |=> active_cnt == $past(active_cnt) + 3'h1
			&& tmr_q[$past(load_idx)] == START_SECS)
		else $error("start did not load a sixty minute timer");

	sph_raise_a: assert property (
		limit_q != 3'h0 && active_cnt >= limit_q && !emerg_press
			&& !start_evt && !(tick && min_val == 12'h001)
			|=> sph_q && sph_lock == $past(min_val) - 12'($past(tick)))
		else $error("starts per hour inhibit missing or wrong lockout");

	limit_off_a: assert property (
		limit_q == 3'h0 |=> !sph_q && limit_q <= `MSIT_LIMIT_MAX)
		else $error("inhibit with limit OFF or limit above five");

	press_clear_a: assert property (
		emerg_press && !start_evt
			|=> !sph_q && tmr_q[$past(min_idx)] == 12'h000)
		else $error("emergency restart did not clear inhibit");

	others_keep_a: assert property (
		quiet_press_s |=> tmr_sum == $past(tmr_sum) - 15'($past(min_val)))
		else $error("emergency restart disturbed other timers");

	press_count_a: assert property (
		quiet_press_s |=> active_cnt == $past(active_cnt) - 3'h1)
		else $error("emergency restart did not free one timer");

	tbs_count_a: assert property (
		tick && tbs_q != 14'h0000 && !start_evt && tbs_min_q != 8'h00
			|=> tbs_q == $past(tbs_q) - 14'h0001)
		else $error("time between starts timer did not count");

	tbs_free_a: assert property (
		tbs_q == 14'h0000 && !sph_q && !ext_inhibit |-> !start_inhibit)
		else $error("lockout with expired time between starts");

	tbs_off_a: assert property (
		tbs_min_q == 8'h00 |=> tbs_q == 14'h0000)
		else $error("time between starts not zero when OFF");

	trip_rec_a: assert property (
		trip_pulse |=> trip_q == $past(trip_cause))
		else $error("trip cause not recorded");

	trip_hold_a: assert property (
		!trip_pulse |=> $stable(trip_q))
		else $error("trip cause changed without a trip");

	event_trip_a: assert property (
		trip_pulse && !inh_rise |=> event_q == {1'b0, trip_q})
		else $error("last event differs from last trip");

	event_inh_a: assert property (
		inh_rise |=> event_q == `MSIT_EVT_INHIBIT)
		else $error("inhibit not recorded as last event");

	inh_only_a: assert property (
		inh_rise && !trip_pulse |=> $stable(trip_q))
		else $error("inhibit changed the trip cause");

	stop_det_a: assert property (
		motor_current_pm < STOP_PM |=> !motor_running)
		else $error("low current not seen as motor stop");
endmodule // msit_top
`default_nettype wire

// ===== tb/msit_motor_model.sv
// Motor current source and emergency restart contact for the bench
`timescale 1ns/1ps
`default_nettype none
module msit_motor_model (
	input wire logic pclk,
	input wire logic run,
	input wire logic press,
	output logic [9:0] current_pm,
	output logic restart_n
);
	initial begin
		current_pm = 10'h000;
		restart_n = 1'b1;
	end
	// Current wanders each cycle so thresholds see varied levels
	always @(posedge pclk) begin
		if (run) begin
			current_pm <= 10'($urandom_range(50, 1023));
		end else begin
			current_pm <= 10'($urandom_range(0, 49));
		end
	end
	// Contact held shut long enough for the synchroniser
	always @(posedge press) begin
		restart_n <= 1'b0;
		repeat (5) @(posedge pclk);
		restart_n <= 1'b1;
	end
endmodule // msit_motor_model
`default_nettype wire

// ===== tb/msit_top_tb.sv
// Self-checking bench for the start supervision block
`timescale 1ns/1ps
`default_nettype none
`include "msit_regs.svh"
module msit_top_tb;
	import msit_pkg::*;
	typedef struct {logic err; logic [31:0] lo; logic [31:0] hi;} msit_exp_s;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, restart_n, motor_running, start_inhibit;
	logic inhibit_trip_relay, first_auxiliary_output;
	logic trip_pulse = 1'b0;
	logic ext_inhibit = 1'b0;
	logic run = 1'b0;
	logic press = 1'b0;
	logic [9:0] current_pm;
	msit_cause_t trip_cause = 4'h0;
	msit_cause_t c;
	msit_exp_s exp_q[$];
	msit_exp_s e;
	int failures = 0;
	int n_compared = 0;

	always #2.5 pclk = ~pclk;

	msit_top #(.TICK_CYCLES(2000)) msit_top_i (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.motor_current_pm(current_pm), .emerg_restart_n(restart_n),
		.trip_pulse(trip_pulse), .trip_cause(trip_cause),
		.ext_inhibit(ext_inhibit), .motor_running(motor_running),
		.start_inhibit(start_inhibit),
		.inhibit_trip_relay(inhibit_trip_relay),
		.first_auxiliary_output(first_auxiliary_output)
	);

	msit_motor_model msit_motor_model_i (
		.pclk(pclk), .run(run), .press(press),
		.current_pm(current_pm), .restart_n(restart_n)
	);

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// Read expectations carry a range, since tick phase is free
	task automatic apb(input logic [11:0] a, input logic w,
		input logic [31:0] d, input logic er, input logic [31:0] lo,
		input logic [31:0] hi);
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		if (!w) exp_q.push_back('{er, lo, hi});
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] lo,
		input logic [31:0] hi);
		apb(a, 1'b0, 32'h0, 1'b0, lo, hi);
	endtask

	task automatic rde(input logic [11:0] a, input logic [31:0] v);
		rd(a, v, v);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(a, 1'b1, d, 1'b0, 32'h0, 32'h0);
	endtask

	task automatic start_stop;
		run <= 1'b1;
		cyc(8);
		run <= 1'b0;
		cyc(8);
	endtask

	task automatic press_once;
		press <= 1'b1;
		cyc(1);
		press <= 1'b0;
		cyc(12);
	endtask

	task automatic trip(input msit_cause_t t, input logic inh);
		@(posedge pclk);
		trip_pulse <= 1'b1;
		trip_cause <= t;
		ext_inhibit <= inh;
		@(posedge pclk);
		trip_pulse <= 1'b0;
		cyc(3);
	endtask

	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite
			&& exp_q.size() > 0) begin
			e = exp_q.pop_front();
			check("pslverr", {31'h0, pslverr}, {31'h0, e.err});
			// Exact reads compare the word, ranged reads membership
			if (e.lo == e.hi) begin
				check("prdata", prdata, e.lo);
			end else begin
				check("prdata in range",
					{31'h0, prdata >= e.lo && prdata <= e.hi}, 32'h1);
			end
		end
	end

	initial begin
		#100000;
		failures++;
		conclude();
	end

	initial begin
		void'($urandom(91067));
		cyc(20);
		presetn <= 1'b1;
		rde(`MSIT_CTRL_OFF, 32'h00010003);
		rde(`MSIT_STAT_OFF, 32'h0);
		rde(`MSIT_TBS_OFF, 32'h0);
		apb(12'h02c, 1'b0, 32'h0, 1'b1, 32'h0, 32'h0);
		apb(12'h002, 1'b0, 32'h0, 1'b1, 32'h0, 32'h0);
		wr(`MSIT_STAT_OFF, 32'hffffffff);
		rde(`MSIT_STAT_OFF, 32'h0);
		// Limit off: starts pile up with no inhibit
		wr(`MSIT_CTRL_OFF, 32'h00010000);
		run <= 1'b1;
		cyc(8);
		#1;
		check("running", {31'h0, motor_running}, 32'h1);
		run <= 1'b0;
		cyc(8);
		#1;
		check("stopped", {31'h0, motor_running}, 32'h0);
		cyc(2100);
		start_stop();
		#1;
		check("inhibit off", {31'h0, start_inhibit}, 32'h0);
		rde(`MSIT_STAT_OFF, 32'h10);
		wr(`MSIT_CTRL_OFF, 32'h00010002);
		cyc(4);
		#1;
		check("inhibit", {31'h0, start_inhibit}, 32'h1);
		check("trip relay", {31'h0, inhibit_trip_relay}, 32'h1);
		check("aux", {31'h0, first_auxiliary_output}, 32'h0);
		rd(`MSIT_SPH_OFF, 32'd3598, 32'd3599);
		rde(`MSIT_EVENT_OFF, 32'h10);
		rde(`MSIT_TRIP_OFF, 32'h0);
		wr(`MSIT_CTRL_OFF, 32'h00030002);
		cyc(4);
		#1;
		check("aux on", {31'h0, first_auxiliary_output}, 32'h1);
		press_once();
		#1;
		check("inhibit clr", {31'h0, start_inhibit}, 32'h0);
		rde(`MSIT_TMR0_OFF, 32'h0);
		rd(`MSIT_TMR0_OFF + 12'h004, 32'd3599, 32'd3600);
		rde(`MSIT_STAT_OFF, 32'h08);
		press_once();
		rde(`MSIT_TMR0_OFF + 12'h004, 32'h0);
		rde(`MSIT_STAT_OFF, 32'h0);
		for (int i = 0; i < 16; i++) begin
			trip(msit_cause_t'(i), 1'b0);
			rde(`MSIT_TRIP_OFF, 32'(i));
			rde(`MSIT_EVENT_OFF, 32'(i));
		end
		c = msit_cause_t'($urandom_range(0, 15));
		trip(c, 1'b1);
		#1;
		check("ext inhibit", {31'h0, start_inhibit}, 32'h1);
		rde(`MSIT_EVENT_OFF, 32'h10);
		rde(`MSIT_TRIP_OFF, {28'h0, c});
		ext_inhibit <= 1'b0;
		wr(`MSIT_CTRL_OFF, 32'h00030007);
		rde(`MSIT_CTRL_OFF, 32'h00030005);
		wr(`MSIT_CTRL_OFF, 32'h00030102);
		start_stop();
		rd(`MSIT_TBS_OFF, 32'd59, 32'd60);
		#1;
		check("tbs lock", {31'h0, start_inhibit}, 32'h1);
		cyc(2000);
		rd(`MSIT_TBS_OFF, 32'd57, 32'd59);
		wr(`MSIT_CTRL_OFF, 32'h00030002);
		rde(`MSIT_TBS_OFF, 32'h0);
		#1;
		check("tbs free", {31'h0, start_inhibit}, 32'h0);
		cyc(4);
		conclude();
	end
endmodule // msit_top_tb
`default_nettype wire
